// File: include/resr_defines.svh
// Constants of the remote event and status reporter: event codes,
// status byte bit positions, queue sizing. Assumes inclusion by name.
`ifndef RESR_DEFINES_SVH
`define RESR_DEFINES_SVH
`define RESR_CODE_NONE 10'd0
`define RESR_CODE_OPC 10'd65
`define RESR_CODE_PWRON 10'd401
`define RESR_CODE_LOCAL 10'd201
`define RESR_CODE_BUF_FULL 10'd203
`define RESR_CODE_IN_OVF 10'd253
`define RESR_CODE_RQS_OFF 10'd260
`define RESR_CODE_PLOT 10'd263
`define RESR_CMD_LO 10'd101
`define RESR_CMD_HI 10'd155
`define RESR_EXE_LO 10'd201
`define RESR_EXE_HI 10'd263
`define RESR_INT_LO 10'd351
`define RESR_SYS_LO 10'd401
`define RESR_SYS_HI 10'd456
`define RESR_WRN_LO 10'd551
`define RESR_WRN_HI 10'd558
`define RESR_STB_BUSY_BIT 4
`define RESR_STB_SRQ_BIT 6
`define RESR_SLOTS 8
`endif

// File: include/resr_pkg.sv
// Types of the remote event and status reporter.
// Assumes the defines header is available to the design.
package resr_pkg;
    typedef enum logic [2:0] {
        RESR_CAT_NONE,
        RESR_CAT_WARN,
        RESR_CAT_SYS,
        RESR_CAT_CMD,
        RESR_CAT_EXE,
        RESR_CAT_INT
    } resr_cat_t;
    // Command-processor request flags, all from the same clock domain
    typedef struct packed {
        logic cmd_start;
        logic needs_srq;
        logic is_plot_abort;
        logic remote;
    } resr_cmd_t;
    typedef enum logic [1:0] {
        RESR_ST_SELFTEST,
        RESR_ST_NORMAL,
        RESR_ST_HALTED
    } resr_state_t;
endpackage : resr_pkg

// File: core/resr_reporter.sv
// Event and status reporter behind the remote command interface.
// Assumes the bus protocol engine, UART and command parser sit outside
// on the same clock; only the poll pin and self-test inputs are async.
`timescale 1ns/1ps
`include "resr_defines.svh"
module resr_reporter #(
    parameter int SLOTS = `RESR_SLOTS
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire resr_pkg::resr_cmd_t cmd_i,
    input wire logic cmd_busy_i,
    input wire logic plot_active_i,
    input wire logic rqs_enable_i,
    input wire logic event_valid_i,
    input wire logic [9:0] event_code_i,
    input wire logic init_cmd_i,
    input wire logic selftest_done_i,
    input wire logic selftest_pass_i,
    input wire logic serial_poll_i,
    input wire logic event_query_i,
    input wire logic dev_clear_i,
    output logic srq_o,
    output logic [7:0] status_byte_o,
    output logic stb_send_o,
    output logic [9:0] query_code_o,
    output logic query_valid_o,
    output logic cmd_accept_o,
    output logic cmd_reject_o,
    output logic dump_output_o,
    output logic normal_op_o
);
    // Pin-side inputs pass three flops; second and third must agree
    logic [2:0] poll_sync_r, done_sync_r, pass_sync_r;
    logic poll_lvl_r, poll_lvl_nxt, done_lvl_r, done_lvl_nxt;
    logic pass_lvl_r, pass_lvl_nxt;
    always_comb
    begin
        poll_lvl_nxt = poll_lvl_r;
        done_lvl_nxt = done_lvl_r;
        pass_lvl_nxt = pass_lvl_r;
        if (poll_sync_r[1] == poll_sync_r[2])
            poll_lvl_nxt = poll_sync_r[2];
        if (done_sync_r[1] == done_sync_r[2])
            done_lvl_nxt = done_sync_r[2];
        if (pass_sync_r[1] == pass_sync_r[2])
            pass_lvl_nxt = pass_sync_r[2];
    end
    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            poll_sync_r <= 3'h0;
            done_sync_r <= 3'h0;
            pass_sync_r <= 3'h0;
            poll_lvl_r <= 1'b0;
            done_lvl_r <= 1'b0;
            pass_lvl_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            poll_sync_r <= {poll_sync_r[1:0], serial_poll_i};
            done_sync_r <= {done_sync_r[1:0], selftest_done_i};
            pass_sync_r <= {pass_sync_r[1:0], selftest_pass_i};
            poll_lvl_r <= poll_lvl_nxt;
            done_lvl_r <= done_lvl_nxt;
            pass_lvl_r <= pass_lvl_nxt;
        end
    end

    // Class of a code; unknown codes are ranked as execution errors
    function automatic resr_pkg::resr_cat_t cat_of(input logic [9:0] c);
        if (c == `RESR_CODE_NONE)
            return resr_pkg::RESR_CAT_NONE;
        else if (c >= `RESR_INT_LO && c < `RESR_SYS_LO)
            return resr_pkg::RESR_CAT_INT;
        else if (c >= `RESR_CMD_LO && c <= `RESR_CMD_HI)
            return resr_pkg::RESR_CAT_CMD;
        else if (c >= `RESR_EXE_LO && c <= `RESR_EXE_HI)
            return resr_pkg::RESR_CAT_EXE;
        else if (c >= `RESR_SYS_LO && c <= `RESR_SYS_HI)
            return resr_pkg::RESR_CAT_SYS;
        else if (c >= `RESR_WRN_LO && c <= `RESR_WRN_HI)
            return resr_pkg::RESR_CAT_WARN;
        else if (c == `RESR_CODE_OPC)
            return resr_pkg::RESR_CAT_SYS;
        else
            return resr_pkg::RESR_CAT_EXE;
    endfunction : cat_of

    // Rank: class in upper bits, inverted code so lower codes win
    function automatic logic [12:0] rank_of(input logic [9:0] c);
        logic [2:0] k;
        unique case (cat_of(c))
            resr_pkg::RESR_CAT_INT: k = 3'h5;
            resr_pkg::RESR_CAT_EXE: k = 3'h4;
            resr_pkg::RESR_CAT_CMD: k = 3'h3;
            resr_pkg::RESR_CAT_SYS: k = 3'h2;
            resr_pkg::RESR_CAT_WARN: k = 3'h1;
            default: k = 3'h0;
        endcase
        return {k, ~c};
    endfunction : rank_of

    // Pending event table; a code already present is not stored twice
    logic [9:0] slot_r [SLOTS];
    logic [9:0] slot_nxt [SLOTS];
    logic norm_r, norm_nxt;
    resr_pkg::resr_state_t mode_r, mode_nxt;
    logic srq_r, srq_nxt, stb_send_r, stb_send_nxt;
    logic [7:0] stb_r, stb_nxt;
    logic [9:0] qcode_r, qcode_nxt;
    logic qvalid_r, qvalid_nxt, acc_r, acc_nxt, rej_r, rej_nxt;
    logic dump_r, dump_nxt, poll_prev_r, done_prev_r;
    logic busy_prev_r;
    logic [9:0] ev_code [2];
    logic [1:0] ev_req;
    int best, nfull;
    logic [12:0] best_rank;
    logic poll_done, st_done;
    logic ev_dup;
    int ev_free;

    assign poll_done = poll_prev_r & ~poll_lvl_r;
    assign st_done = done_lvl_r & ~done_prev_r;

    always_comb
    begin
        for (int i = 0; i < SLOTS; i++)
            slot_nxt[i] = slot_r[i];
        mode_nxt = mode_r;
        srq_nxt = srq_r;
        stb_nxt = stb_r;
        stb_send_nxt = 1'b0;
        qcode_nxt = qcode_r;
        qvalid_nxt = 1'b0;
        acc_nxt = 1'b0;
        rej_nxt = 1'b0;
        dump_nxt = 1'b0;
        ev_req = 2'b00;
        ev_code[0] = `RESR_CODE_NONE;
        ev_code[1] = `RESR_CODE_NONE;
        best = 0;
        best_rank = 13'h0;
        nfull = 0;
        ev_dup = 1'b0;
        ev_free = -1;
        // Most serious pending entry
        for (int i = 0; i < SLOTS; i++)
        begin
            if (slot_r[i] != `RESR_CODE_NONE)
                nfull++;
            if (slot_r[i] != `RESR_CODE_NONE &&
                rank_of(slot_r[i]) > best_rank)
            begin
                best_rank = rank_of(slot_r[i]);
                best = i;
            end
        end
        // Command screening: local, plot and enable checks
        if (cmd_i.cmd_start)
        begin
            if (!cmd_i.remote)
                ev_code[0] = `RESR_CODE_LOCAL;
            else if (plot_active_i && !cmd_i.is_plot_abort)
                ev_code[0] = `RESR_CODE_PLOT;
            else if (cmd_i.needs_srq && !rqs_enable_i)
                ev_code[0] = `RESR_CODE_RQS_OFF;
            if (ev_code[0] != `RESR_CODE_NONE)
            begin
                ev_req[0] = 1'b1;
                rej_nxt = 1'b1;
            end
            else
                acc_nxt = 1'b1;
        end
        if (event_valid_i)
        begin
            ev_req[1] = 1'b1;
            ev_code[1] = event_code_i;
            if (event_code_i == `RESR_CODE_BUF_FULL)
                dump_nxt = 1'b1;
        end
        if (st_done)
        begin
            ev_req[1] = 1'b1;
            ev_code[1] = `RESR_CODE_OPC;
            mode_nxt = pass_lvl_r ? resr_pkg::RESR_ST_NORMAL
                                  : resr_pkg::RESR_ST_HALTED;
        end
        // Event query takes the most serious entry; zero when empty
        if (event_query_i)
        begin
            qvalid_nxt = 1'b1;
            qcode_nxt = slot_r[best];
            slot_nxt[best] = `RESR_CODE_NONE;
        end
        // Poll end: the poll reported the top entry; re-raise if more remain
        if (poll_done)
            srq_nxt = (nfull > 1);
        // Device clear keeps only the power-on entry
        if (dev_clear_i)
        begin
            srq_nxt = 1'b0;
            for (int i = 0; i < SLOTS; i++)
                if (slot_r[i] != `RESR_CODE_PWRON)
                    slot_nxt[i] = `RESR_CODE_NONE;
                else
                    srq_nxt = 1'b1;
            dump_nxt = 1'b1;
        end
        // Store new events; overflow of the table drops the newest
        for (int e = 0; e < 2; e++)
        begin
            if (ev_req[e])
            begin
                ev_dup = 1'b0;
                ev_free = -1;
                for (int i = 0; i < SLOTS; i++)
                begin
                    if (slot_nxt[i] == ev_code[e])
                        ev_dup = 1'b1;
                    if (slot_nxt[i] == `RESR_CODE_NONE && ev_free < 0)
                        ev_free = i;
                end
                if (!ev_dup && ev_free >= 0)
                    slot_nxt[ev_free] = ev_code[e];
                srq_nxt = 1'b1;
                stb_send_nxt = 1'b1;
            end
        end
        if (cmd_busy_i != busy_prev_r)
            stb_send_nxt = 1'b1;
        // Reinitialise: back to power-up state, power-on entry, self test
        if (init_cmd_i)
        begin
            for (int i = 0; i < SLOTS; i++)
                slot_nxt[i] = `RESR_CODE_NONE;
            slot_nxt[0] = `RESR_CODE_PWRON;
            mode_nxt = resr_pkg::RESR_ST_SELFTEST;
            srq_nxt = 1'b1;
            dump_nxt = 1'b1;
        end
        // Registered so the operating-state pin never glitches
        norm_nxt = (mode_nxt == resr_pkg::RESR_ST_NORMAL);
        // Status byte: SRQ bit, busy bit, category of the top entry
        stb_nxt = 8'h00;
        stb_nxt[`RESR_STB_SRQ_BIT] = srq_nxt;
        stb_nxt[`RESR_STB_BUSY_BIT] = cmd_busy_i;
        stb_nxt[2:0] = 3'(cat_of(slot_r[best]));
        if (poll_lvl_r)
            stb_nxt = stb_r; // Hold steady while the poll reads it
    end

    always_ff @(posedge clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < SLOTS; i++)
                slot_r[i] <= `RESR_CODE_NONE;
            slot_r[0] <= `RESR_CODE_PWRON;
            mode_r <= resr_pkg::RESR_ST_SELFTEST;
            norm_r <= 1'b0;
            srq_r <= 1'b1;
            stb_r <= 8'h40;
            stb_send_r <= 1'b0;
            qcode_r <= `RESR_CODE_NONE;
            qvalid_r <= 1'b0;
            acc_r <= 1'b0;
            rej_r <= 1'b0;
            dump_r <= 1'b0;
            poll_prev_r <= 1'b0;
            done_prev_r <= 1'b0;
            busy_prev_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            for (int i = 0; i < SLOTS; i++)
                slot_r[i] <= slot_nxt[i];
            mode_r <= mode_nxt;
            norm_r <= norm_nxt;
            srq_r <= srq_nxt;
            stb_r <= stb_nxt;
            stb_send_r <= stb_send_nxt;
            qcode_r <= qcode_nxt;
            qvalid_r <= qvalid_nxt;
            acc_r <= acc_nxt;
            rej_r <= rej_nxt;
            dump_r <= dump_nxt;
            poll_prev_r <= poll_lvl_r;
            done_prev_r <= done_lvl_r;
            busy_prev_r <= cmd_busy_i;
        end
    end

    assign srq_o = srq_r;
    assign status_byte_o = stb_r;
    assign stb_send_o = stb_send_r;
    assign query_code_o = qcode_r;
    assign query_valid_o = qvalid_r;
    assign cmd_accept_o = acc_r;
    assign cmd_reject_o = rej_r;
    assign dump_output_o = dump_r;
    assign normal_op_o = norm_r;
endmodule : resr_reporter

// File: bench/resr_checker.sv
// Port assertions for the event and status reporter.
// Assumes a bind onto resr_reporter; one clock, async high reset.
`timescale 1ns/1ps
module resr_checker #(
    parameter int SLOTS = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic clk_en_i,
    input wire resr_pkg::resr_cmd_t cmd_i,
    input wire logic cmd_busy_i,
    input wire logic plot_active_i,
    input wire logic event_valid_i,
    input wire logic [9:0] event_code_i,
    input wire logic init_cmd_i,
    input wire logic serial_poll_i,
    input wire logic srq_o,
    input wire logic [7:0] status_byte_o,
    input wire logic stb_send_o,
    input wire logic cmd_reject_o,
    input wire logic dump_output_o,
    input wire logic normal_op_o
);
    // One domain, so clock and reset are stated once
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Init wins over an event in the same cycle
    sequence s_cmd;
        clk_en_i && cmd_i.cmd_start;
    endsequence
    sequence s_ev;
        clk_en_i && event_valid_i && !init_cmd_i;
    endsequence
    chk_poweron_srq:
        assert property ($fell(sys_rst_i) |-> srq_o)
        else $error("no power-on request");
    chk_local_reject:
        assert property (s_cmd ##0 !cmd_i.remote |=> cmd_reject_o)
        else $error("local command taken");
    chk_plot_reject:
        assert property (s_cmd ##0 plot_active_i && !cmd_i.is_plot_abort
            |=> cmd_reject_o)
        else $error("command taken in plot");
    chk_event_srq:
        assert property (s_ev |=> srq_o)
        else $error("event without request");
    chk_event_send:
        assert property (s_ev |=> stb_send_o)
        else $error("event without send");
    chk_full_dump:
        assert property (s_ev ##0 event_code_i == 10'h0cb |=> dump_output_o)
        else $error("full without dump");
    chk_busy_bit:
        assert property ((clk_en_i && !serial_poll_i)[*8]
            |=> status_byte_o[4] == $past(cmd_busy_i))
        else $error("busy bit wrong");
    chk_init_state:
        assert property (clk_en_i && init_cmd_i |=> !normal_op_o && srq_o)
        else $error("init did not restart");
endmodule : resr_checker

bind resr_reporter resr_checker #(.SLOTS(SLOTS)) resr_checker_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
    .cmd_i(cmd_i), .cmd_busy_i(cmd_busy_i), .plot_active_i(plot_active_i),
    .event_valid_i(event_valid_i), .event_code_i(event_code_i),
    .init_cmd_i(init_cmd_i), .serial_poll_i(serial_poll_i), .srq_o(srq_o),
    .status_byte_o(status_byte_o), .stb_send_o(stb_send_o),
    .cmd_reject_o(cmd_reject_o), .dump_output_o(dump_output_o),
    .normal_op_o(normal_op_o)
);

// File: bench/resr_host.sv
// Host model: serial poll and event query, driven on falling edges.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module resr_host (
    input wire logic clk_i,
    input wire logic [7:0] status_byte_i,
    input wire logic [9:0] query_code_i,
    input wire logic query_valid_i,
    output logic serial_poll_o = 1'b0,
    output logic event_query_o = 1'b0
);
    // Query pulse; a missing answer reads as all ones
    task automatic query(output logic [9:0] code);
        @(negedge clk_i) event_query_o = 1'b1;
        @(negedge clk_i) event_query_o = 1'b0;
        code = query_valid_i ? query_code_i : 10'h3ff;
    endtask : query
    // Poll length varies, so a slow host is modelled too
    task automatic service(input int hold, output logic [7:0] stb,
        output logic [9:0] code);
        @(negedge clk_i) serial_poll_o = 1'b1;
        repeat (hold + 5) @(negedge clk_i);
        stb = status_byte_i;
        serial_poll_o = 1'b0;
        repeat (8) @(negedge clk_i);
        query(code);
    endtask : service
endmodule : resr_host

// File: bench/remote_event_status_reporter_tb.sv
// Bench for the reporter: corner and random traffic, host model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
module remote_event_status_reporter_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    resr_pkg::resr_cmd_t cmd = '0;
    logic busy = 1'b0;
    logic plot = 1'b0;
    logic request_service_enable = 1'b0;
    logic ev_v = 1'b0;
    logic [9:0] ev_c = 10'h0;
    logic init = 1'b0;
    logic done = 1'b0;
    logic pass = 1'b0;
    logic clr = 1'b0;
    logic en = 1'b1;
    logic poll, query, srq, send, qv, acc, rej, dump, nop;
    logic [7:0] stb;
    logic [9:0] qc;
    int num_errors = 0;
    int n_tests = 0;
    // 25 MHz
    always #20 clk_i = ~clk_i;
    resr_reporter #(.SLOTS(8)) resr_reporter_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(en),
        .cmd_i(cmd), .cmd_busy_i(busy), .plot_active_i(plot),
        .rqs_enable_i(request_service_enable), .event_valid_i(ev_v), .event_code_i(ev_c),
        .init_cmd_i(init), .selftest_done_i(done), .selftest_pass_i(pass),
        .serial_poll_i(poll), .event_query_i(query), .dev_clear_i(clr),
        .srq_o(srq), .status_byte_o(stb), .stb_send_o(send),
        .query_code_o(qc), .query_valid_o(qv), .cmd_accept_o(acc),
        .cmd_reject_o(rej), .dump_output_o(dump), .normal_op_o(nop)
    );
    resr_host resr_host_i (
        .clk_i(clk_i), .status_byte_i(stb), .query_code_i(qc),
        .query_valid_i(qv), .serial_poll_o(poll), .event_query_o(query)
    );
    // Mismatches are printed at once and counted
    task automatic cmp_val(input logic [9:0] a, input logic [9:0] e);
        n_tests++;
        if (a !== e)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask : cmp_val
    task automatic cmp_flag(input logic a, input logic e);
        cmp_val({9'h0, a}, {9'h0, e});
    endtask : cmp_flag
    // Bits: remote, plot, abort, needs request, enable; 0 means accept
    function automatic logic [9:0] exp_rej(input logic [4:0] c);
        return !c[4] ? 10'h0c9 : (c[3] && !c[2]) ? 10'h107 :
            (c[1] && !c[0]) ? 10'h104 : 10'h0;
    endfunction : exp_rej
    // One event; its answers are registered a cycle later
    task automatic ev(input logic [9:0] c);
        @(negedge clk_i);
        ev_v = 1'b1;
        ev_c = c;
        @(negedge clk_i) ev_v = 1'b0;
        cmp_flag(send, 1'b1);
        cmp_flag(srq, 1'b1);
        cmp_flag(dump, c == 10'h0cb);
    endtask : ev
    task automatic q(input logic [9:0] e);
        logic [9:0] c;
        resr_host_i.query(c);
        cmp_val(c, e);
    endtask : q
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // A hang counts as a mismatch; the run needs under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        logic [7:0] sb;
        logic [9:0] c;
        logic [9:0] w [5];
        void'($urandom(9));
        repeat (8) @(posedge clk_i);
        @(negedge clk_i) sys_rst_i = 1'b0;
        // Power-on request: poll, query, then quiet
        resr_host_i.service(3, sb, c);
        cmp_val({2'h0, sb}, 10'h042);
        cmp_val(c, 10'h191);
        repeat (2) @(negedge clk_i);
        cmp_flag(srq, 1'b0);
        // Reinit with a failing, then a passing self test
        for (int p = 0; p < 2; p++)
        begin
            @(negedge clk_i) init = 1'b1;
            @(negedge clk_i) init = 1'b0;
            cmp_flag(nop, 1'b0);
            cmp_flag(srq, 1'b1);
            pass = p[0];
            done = 1'b1;
            repeat (8) @(negedge clk_i);
            cmp_flag(nop, p[0]);
            q(10'h041);
            q(10'h191);
            done = 1'b0;
            repeat (8) @(negedge clk_i);
        end
        // Codes of five classes, random but for the fixed internal one, raised least serious first
        w[0] = 10'h15f;
        w[1] = 10'h0fb + 10'($urandom % 13);
        w[2] = 10'h065 + 10'($urandom % 9);
        w[3] = 10'h1c3 + 10'($urandom % 6);
        w[4] = 10'h227 + 10'($urandom % 8);
        for (int i = 4; i >= 0; i--) ev(w[i]);
        resr_host_i.service(1 + $urandom % 8, sb, c);
        cmp_val({2'h0, sb}, 10'h045);
        cmp_val(c, w[0]);
        cmp_flag(srq, 1'b1);
        for (int i = 1; i < 5; i++) q(w[i]);
        q(10'h0);
        // Every command qualifier combination
        for (int i = 0; i < 32; i++)
        begin
            c = exp_rej(5'(i));
            @(negedge clk_i);
            {cmd.remote, plot, cmd.is_plot_abort, cmd.needs_srq, request_service_enable} = 5'(i);
            cmd.cmd_start = 1'b1;
            @(negedge clk_i) cmd.cmd_start = 1'b0;
            cmp_flag(rej, c != 10'h0);
            cmp_flag(acc, c == 10'h0);
            q(c);
        end
        busy = 1'b1;
        repeat (10) @(negedge clk_i);
        cmp_flag(stb[4], 1'b1);
        busy = 1'b0;
        // Device clear drops pending errors and the request
        ev(10'h0cb);
        ev(10'h0fd);
        @(negedge clk_i) clr = 1'b1;
        @(negedge clk_i) clr = 1'b0;
        repeat (2) @(negedge clk_i);
        cmp_flag(srq, 1'b0);
        q(10'h0);
        // Clock enable low: an event pulse must leave no trace
        @(negedge clk_i) en = 1'b0;
        ev_v = 1'b1;
        ev_c = 10'h1c5;
        @(negedge clk_i) ev_v = 1'b0;
        repeat (2) @(negedge clk_i);
        cmp_flag(srq, 1'b0);
        en = 1'b1;
        q(10'h0);
        tally_and_finish();
    end
endmodule : remote_event_status_reporter_tb
